// *** rtl/hot_plug_slot_status_regs.sv ***
`timescale 1ns/10ps
module hot_plug_slot_status_regs (
  input  wire logic                        i_clk,
  input  wire logic                        i_rst_b,
  input  wire logic [7:0]                  i_avs_address,
  input  wire logic                        i_avs_read,
  input  wire logic                        i_avs_write,
  input  wire logic [31:0]                 i_avs_writedata,
  input  wire logic [3:0]                  i_avs_byteenable,
  output logic      [31:0]                 o_avs_readdata,
  output logic                             o_avs_waitrequest,
  input  wire slot_regs_pkg::slot_in_t     i_slot [slot_regs_pkg::NUM_SLOTS],
  output logic      [3:0]                  o_slot_irq_pending,
  output logic      [3:0]                  o_slot_syserr_pending
);

  // ----------------------------------------------------------------
  // Storage
  // ----------------------------------------------------------------
  logic [6:0]                  mask_r      [slot_regs_pkg::NUM_SLOTS];
  slot_regs_pkg::event_t       event_r     [slot_regs_pkg::NUM_SLOTS];
  slot_regs_pkg::slot_in_t     prev_r      [slot_regs_pkg::NUM_SLOTS];
  slot_regs_pkg::slot_in_t     cur_r       [slot_regs_pkg::NUM_SLOTS];
  logic                        primed_r;
  logic                        ack_r;
  logic                        waitreq_r;
  logic [31:0]                 readdata_r;
  logic [3:0]                  irq_r;
  logic [3:0]                  serr_r;

  function automatic logic [31:0] pack_slot(input logic [6:0] m,
                                            input slot_regs_pkg::event_t e,
                                            input slot_regs_pkg::slot_in_t s);
    pack_slot = {1'b0, m, 3'h0, e, 2'h0, s};
  endfunction

  function automatic logic [31:0] be_mask(input logic [3:0] be);
    be_mask = {{8{be[3]}}, {8{be[2]}}, {8{be[1]}}, {8{be[0]}}};
  endfunction

  function automatic logic rising(input logic now_v, input logic was_v);
    rising = now_v & ~was_v;
  endfunction

  // ----------------------------------------------------------------
  // Bus decode
  // ----------------------------------------------------------------
  wire        req       = (i_avs_read | i_avs_write) & ~ack_r;
  wire [31:0] wmask     = be_mask(i_avs_byteenable);
  wire [31:0] wbits     = i_avs_writedata & wmask;
  logic [3:0] sel;
  assign sel[0] = (i_avs_address == slot_regs_pkg::SLOT1_OFFSET);
  assign sel[1] = (i_avs_address == slot_regs_pkg::SLOT2_OFFSET);
  assign sel[2] = (i_avs_address == slot_regs_pkg::SLOT3_OFFSET);
  assign sel[3] = (i_avs_address == slot_regs_pkg::SLOT4_OFFSET);
  wire sel_sum  = (i_avs_address == slot_regs_pkg::SUMMARY_OFFSET);
  // Writes land on the answer edge, where the master sees waitrequest low
  wire do_write = ack_r & i_avs_write;

  // ----------------------------------------------------------------
  // Per-slot logic
  // ----------------------------------------------------------------
  logic [31:0]           slot_word [slot_regs_pkg::NUM_SLOTS];
  slot_regs_pkg::event_t hit       [slot_regs_pkg::NUM_SLOTS];
  slot_regs_pkg::event_t clr       [slot_regs_pkg::NUM_SLOTS];
  slot_regs_pkg::event_t ev_nxt    [slot_regs_pkg::NUM_SLOTS];
  logic [6:0]            mask_nxt  [slot_regs_pkg::NUM_SLOTS];
  logic [3:0]            irq_nxt;
  logic [3:0]            serr_nxt;

  genvar g;
  generate
    for (g = 0; g < slot_regs_pkg::NUM_SLOTS; g++) begin : gen_slot
      wire slot_regs_pkg::slot_in_t c = cur_r[g];
      wire slot_regs_pkg::slot_in_t p = prev_r[g];
      wire fault_rise = rising(c.power_fault_latch, p.power_fault_latch);
      wire enabled    = (c.slot_state == slot_regs_pkg::SLOT_STATE_ENABLED);
      assign hit[g].conn_fault      = primed_r & fault_rise & enabled;
      assign hit[g].iso_fault       = primed_r & fault_rise & ~enabled;
      assign hit[g].latch_change    = primed_r &
                                      (c.retention_latch_open ^ p.retention_latch_open);
      assign hit[g].button_press    = primed_r & rising(c.attention_button_level,
                                                        p.attention_button_level);
      assign hit[g].presence_change = primed_r &
                                      (c.card_presence_code != p.card_presence_code);
      assign clr[g] = (do_write & sel[g]) ?
                      wbits[slot_regs_pkg::BIT_EVENT_HI:slot_regs_pkg::BIT_EVENT_LO] : 5'h0;
      assign ev_nxt[g] = (event_r[g] & ~clr[g]) | hit[g];
      assign slot_word[g] = pack_slot(mask_r[g], event_r[g], c);
      assign mask_nxt[g] = (do_write & sel[g]) ?
                           ((mask_r[g] & ~wmask[30:24]) | wbits[30:24]) : mask_r[g];
      // Pendings follow the next event and mask, so they match the register view
      assign irq_nxt[g] = |(ev_nxt[g] & ~mask_nxt[g][4:0]);
      assign serr_nxt[g] = (ev_nxt[g].conn_fault & ~mask_nxt[g][6]) |
                           (ev_nxt[g].latch_change & ~mask_nxt[g][5]);
    end
  endgenerate

  // ----------------------------------------------------------------
  // Read mux
  // ----------------------------------------------------------------
  wire [31:0] rd_mux =
    sel[0]  ? slot_word[0] :
    sel[1]  ? slot_word[1] :
    sel[2]  ? slot_word[2] :
    sel[3]  ? slot_word[3] :
    sel_sum ? {20'h0, serr_r, 4'h0, irq_r} : slot_regs_pkg::UNMAPPED_DATA;

  // ----------------------------------------------------------------
  // Registers
  // ----------------------------------------------------------------
  always_ff @(posedge i_clk) begin
    if (!i_rst_b) begin
      primed_r   <= 1'b0;
      ack_r      <= 1'b0;
      waitreq_r  <= 1'b1;
      readdata_r <= 32'h0;
      irq_r      <= 4'h0;
      serr_r     <= 4'h0;
    end else begin
      primed_r   <= 1'b1;
      ack_r      <= req;
      waitreq_r  <= ~req;
      readdata_r <= (req & i_avs_read) ? rd_mux : readdata_r;
      irq_r      <= irq_nxt;
      serr_r     <= serr_nxt;
    end
  end

  // ----------------------------------------------------------------
  // Slot input samples
  // ----------------------------------------------------------------
  always_ff @(posedge i_clk) begin
    for (int i = 0; i < slot_regs_pkg::NUM_SLOTS; i++) begin
      cur_r[i]  <= i_slot[i];
      prev_r[i] <= cur_r[i];
    end
  end

  // ----------------------------------------------------------------
  // Event and mask bits
  // ----------------------------------------------------------------
  always_ff @(posedge i_clk) begin
    for (int i = 0; i < slot_regs_pkg::NUM_SLOTS; i++) begin
      if (!i_rst_b) begin
        event_r[i] <= 5'h0;
      end else begin
        event_r[i] <= ev_nxt[i];
      end
    end
  end

  always_ff @(posedge i_clk) begin
    for (int i = 0; i < slot_regs_pkg::NUM_SLOTS; i++) begin
      if (!i_rst_b) begin
        mask_r[i] <= slot_regs_pkg::SLOT_RESET[30:24];
      end else begin
        mask_r[i] <= mask_nxt[i];
      end
    end
  end

  // Wait one cycle per access; answer on the next edge
  assign o_avs_waitrequest     = waitreq_r;
  assign o_avs_readdata        = readdata_r;
  assign o_slot_irq_pending    = irq_r;
  assign o_slot_syserr_pending = serr_r;

  // ----------------------------------------------------------------
  // Bus checks
  // ----------------------------------------------------------------
  default clocking cb @(posedge i_clk); endclocking
  default disable iff (!i_rst_b);

  a_answer_one_cycle: assert property (
    (i_avs_read || i_avs_write) && o_avs_waitrequest |=> !o_avs_waitrequest)
    else $error("bus answer late");
  a_wait_idle_high: assert property (
    !(i_avs_read || i_avs_write) |=> o_avs_waitrequest)
    else $error("wait request low while idle");
  a_wait_low_once: assert property (
    !o_avs_waitrequest |=> o_avs_waitrequest)
    else $error("wait request low too long");
  a_write_at_answer: assert property (
    do_write |-> !o_avs_waitrequest)
    else $error("write outside answer cycle");
  a_read_unmapped: assert property (
    req && i_avs_read && !(|sel) && !sel_sum |=> o_avs_readdata == 32'h0)
    else $error("unmapped read not zero");
  a_read_reserved: assert property (
    req && i_avs_read |=> !o_avs_readdata[31] && o_avs_readdata[23:21] == 3'h0
    && o_avs_readdata[15:14] == 2'h0)
    else $error("reserved bits not zero");

  // ----------------------------------------------------------------
  // Readback checks
  // ----------------------------------------------------------------
  a_read_inputs: assert property (
    req && i_avs_read && sel[0] |=> o_avs_readdata[13:0] == $past(cur_r[0]))
    else $error("read-only fields wrong");
  a_read_events: assert property (
    req && i_avs_read && sel[0] |=> o_avs_readdata[20:16] == $past(event_r[0]))
    else $error("event field read wrong");
  a_read_masks: assert property (
    req && i_avs_read && sel[0] |=> o_avs_readdata[30:24] == $past(mask_r[0]))
    else $error("mask field read wrong");
  a_read_summary: assert property (
    req && i_avs_read && sel_sum
    |=> o_avs_readdata == {20'h0, $past(serr_r), 4'h0, $past(irq_r)})
    else $error("summary read wrong");
  a_inputs_sampled: assert property (
    cur_r[0] == $past(i_slot[0]))
    else $error("slot inputs not sampled");

  // ----------------------------------------------------------------
  // Event checks
  // ----------------------------------------------------------------
  a_button_rise_sets: assert property (
    primed_r && cur_r[0].attention_button_level && !prev_r[0].attention_button_level
    |=> event_r[0].button_press) else $error("button press not recorded");
  a_button_release_quiet: assert property (
    !event_r[0].button_press && !cur_r[0].attention_button_level
    && prev_r[0].attention_button_level |=> !event_r[0].button_press)
    else $error("release set press event");
  a_conn_fault_sets: assert property (
    primed_r && cur_r[0].power_fault_latch && !prev_r[0].power_fault_latch
    && cur_r[0].slot_state == 2'h2 |=> event_r[0].conn_fault && !$rose(event_r[0].iso_fault))
    else $error("connected fault mis-set");
  a_conn_fault_quiet: assert property (
    !event_r[0].conn_fault
    && !(cur_r[0].power_fault_latch && !prev_r[0].power_fault_latch)
    |=> !event_r[0].conn_fault) else $error("connected fault set without rise");
  a_iso_fault_sets: assert property (
    primed_r && cur_r[0].power_fault_latch && !prev_r[0].power_fault_latch
    && cur_r[0].slot_state != 2'h2 |=> event_r[0].iso_fault)
    else $error("isolated fault not set");
  a_iso_fault_quiet: assert property (
    !event_r[0].iso_fault
    && !(cur_r[0].power_fault_latch && !prev_r[0].power_fault_latch)
    |=> !event_r[0].iso_fault) else $error("isolated fault set without rise");
  a_latch_change_sets: assert property (
    primed_r && (cur_r[0].retention_latch_open != prev_r[0].retention_latch_open)
    |=> event_r[0].latch_change) else $error("latch change lost");
  a_latch_quiet: assert property (
    !event_r[0].latch_change
    && cur_r[0].retention_latch_open == prev_r[0].retention_latch_open
    |=> !event_r[0].latch_change) else $error("latch event without change");
  a_presence_sets: assert property (
    primed_r && (cur_r[0].card_presence_code != prev_r[0].card_presence_code)
    |=> event_r[0].presence_change) else $error("presence change lost");
  a_presence_quiet: assert property (
    !event_r[0].presence_change
    && cur_r[0].card_presence_code == prev_r[0].card_presence_code
    |=> !event_r[0].presence_change) else $error("presence event without change");
  a_no_event_unprimed: assert property (
    !primed_r |=> event_r[0] == 5'h0)
    else $error("event set before inputs settled");

  // ----------------------------------------------------------------
  // Clear checks
  // ----------------------------------------------------------------
  a_w1c_clears: assert property (
    do_write && sel[0] && i_avs_byteenable[2] && i_avs_writedata[19]
    && !hit[0].latch_change
    |=> !event_r[0].latch_change) else $error("write one did not clear");
  a_w0_keeps: assert property (
    do_write && sel[0] && event_r[0].latch_change && !i_avs_writedata[19]
    |=> event_r[0].latch_change) else $error("write zero cleared event");
  a_event_sticky: assert property (
    event_r[0].presence_change
    && !(do_write && sel[0] && i_avs_byteenable[2] && i_avs_writedata[16])
    |=> event_r[0].presence_change) else $error("event dropped without clear");
  a_set_beats_clear: assert property (
    hit[0].latch_change && do_write && sel[0]
    |=> event_r[0].latch_change) else $error("clear beat hardware set");

  // ----------------------------------------------------------------
  // Mask and pending checks
  // ----------------------------------------------------------------
  a_mask_write_lands: assert property (
    do_write && sel[0] && i_avs_byteenable[3]
    |=> mask_r[0] == $past(i_avs_writedata[30:24])) else $error("mask write lost");
  a_mask_holds: assert property (
    !(do_write && sel[0])
    |=> $stable(mask_r[0])) else $error("mask changed without write");
  a_irq_masked_quiet: assert property (
    (&mask_r[0][4:0]) |-> !irq_r[0])
    else $error("masked slot raised interrupt");
  a_conn_syserr_mask: assert property (
    serr_r[0] && !event_r[0].latch_change |-> !mask_r[0][6] && event_r[0].conn_fault)
    else $error("connected fault system error mask ignored");
  a_latch_syserr_mask: assert property (
    serr_r[0] && !event_r[0].conn_fault |-> !mask_r[0][5] && event_r[0].latch_change)
    else $error("latch system error mask ignored");
  a_irq_pending: assert property (
    irq_r[0] == |(event_r[0] & ~mask_r[0][4:0]))
    else $error("interrupt pending wrong");
  a_serr_pending: assert property (
    serr_r[0] == ((event_r[0].conn_fault & ~mask_r[0][6])
                  | (event_r[0].latch_change & ~mask_r[0][5])))
    else $error("system error pending wrong");

  generate
    for (g = 0; g < slot_regs_pkg::NUM_SLOTS; g++) begin : gen_chk
      a_irq_each: assert property (
        o_slot_irq_pending[g] == |(event_r[g] & ~mask_r[g][4:0]))
        else $error("slot interrupt pending wrong");
      a_serr_each: assert property (
        o_slot_syserr_pending[g] == ((event_r[g].conn_fault & ~mask_r[g][6])
                                     | (event_r[g].latch_change & ~mask_r[g][5])))
        else $error("slot system error pending wrong");
    end
  endgenerate

  // ----------------------------------------------------------------
  // Coverage
  // ----------------------------------------------------------------
  c_button_event: cover property (event_r[0].button_press);
  c_conn_fault:   cover property (event_r[0].conn_fault);
  c_set_and_clear: cover property (do_write && sel[0] && |hit[0]);
  c_irq_raised:   cover property ($rose(o_slot_irq_pending[0]));
  c_serr_raised:  cover property ($rose(o_slot_syserr_pending[0]));

endmodule

// *** shared/slot_regs_pkg.sv ***
package slot_regs_pkg;

  // ----------------------------------------------------------------
  // Register map
  // ----------------------------------------------------------------
  localparam int          NUM_SLOTS       = 4;
  localparam logic [7:0]  SLOT1_OFFSET    = 8'h24;
  localparam logic [7:0]  SLOT2_OFFSET    = 8'h28;
  localparam logic [7:0]  SLOT3_OFFSET    = 8'h2c;
  localparam logic [7:0]  SLOT4_OFFSET    = 8'h30;
  localparam logic [7:0]  SUMMARY_OFFSET  = 8'h34;
  localparam logic [31:0] SLOT_RESET      = 32'h7f003f3f;
  localparam logic [31:0] UNMAPPED_DATA   = 32'h00000000;

  // ----------------------------------------------------------------
  // Field positions
  // ----------------------------------------------------------------
  localparam int BIT_CONN_FAULT_SYSERR_MASK  = 30;
  localparam int BIT_LATCH_CHANGE_SYSERR_MASK = 29;
  localparam int BIT_IRQ_MASK_LO             = 24;
  localparam int BIT_IRQ_MASK_HI             = 28;
  localparam int BIT_EVENT_LO                = 16;
  localparam int BIT_EVENT_HI                = 20;
  localparam int BIT_CONN_FAULT_EVENT        = 20;
  localparam int BIT_LATCH_CHANGE_EVENT      = 19;
  localparam int BIT_BUTTON_PRESS_EVENT      = 18;
  localparam int BIT_ISO_FAULT_EVENT         = 17;
  localparam int BIT_PRESENCE_CHANGE_EVENT   = 16;
  localparam int BIT_SUMMARY_SYSERR_LO       = 8;

  localparam logic [1:0] SLOT_STATE_ENABLED  = 2'h2;

  // ----------------------------------------------------------------
  // Slot-side inputs
  // ----------------------------------------------------------------
  typedef struct packed {
    logic [1:0] card_bus_capability;
    logic [1:0] card_presence_code;
    logic       card_fast_conventional;
    logic       retention_latch_open;
    logic       attention_button_level;
    logic       power_fault_latch;
    logic [1:0] attention_led_state;
    logic [1:0] power_led_state;
    logic [1:0] slot_state;
  } slot_in_t;

  // Event bits, index order matches bits 20..16
  typedef struct packed {
    logic conn_fault;
    logic latch_change;
    logic button_press;
    logic iso_fault;
    logic presence_change;
  } event_t;

endpackage

// *** sim/slot_side_model.sv ***
`timescale 1ns/10ps
// ----------------------------------------------------------------
// Slot sensors: debounced levels launched on the bridge clock
// ----------------------------------------------------------------
module slot_side_model (
  input  wire logic                    i_clk,
  input  wire slot_regs_pkg::slot_in_t i_want [slot_regs_pkg::NUM_SLOTS],
  output slot_regs_pkg::slot_in_t      o_slot [slot_regs_pkg::NUM_SLOTS]
);
  always @(posedge i_clk) begin
    o_slot <= i_want;
  end
endmodule

// *** sim/hot_plug_slot_status_regs_tb.sv ***
`timescale 1ns/10ps
module hot_plug_slot_status_regs_tb;
  logic                    clk;
  logic                    rst_b;
  logic                    rd;
  logic                    wr;
  logic [7:0]              addr;
  logic [31:0]             wdata;
  logic [31:0]             rdata;
  logic [31:0]             q;
  logic                    waitreq;
  logic [3:0]              irq_p;
  logic [3:0]              serr_p;
  logic [6:0]              mask;
  logic [6:0]              pats [3] = '{7'h55, 7'h2a, 7'h00};
  slot_regs_pkg::slot_in_t want [slot_regs_pkg::NUM_SLOTS];
  slot_regs_pkg::slot_in_t slot [slot_regs_pkg::NUM_SLOTS];
  slot_regs_pkg::slot_in_t v;
  int                      n_mismatch;
  int                      num_checks;
  int                      cyc;

  slot_side_model i_model (.i_clk(clk), .i_want(want), .o_slot(slot));
  hot_plug_slot_status_regs i_dut (.i_clk(clk), .i_rst_b(rst_b), .i_avs_address(addr),
    .i_avs_read(rd), .i_avs_write(wr), .i_avs_writedata(wdata), .i_avs_byteenable(4'hf),
    .o_avs_readdata(rdata), .o_avs_waitrequest(waitreq), .i_slot(slot),
    .o_slot_irq_pending(irq_p), .o_slot_syserr_pending(serr_p));

  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end

  // ----------------------------------------------------------------
  // Bus access, compare and verdict
  // ----------------------------------------------------------------
  task automatic give_verdict();
    if (n_mismatch == 0 && num_checks > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    num_checks++;
    if (got !== exp) begin
      n_mismatch++;
      $display("MISMATCH %0t got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
    addr <= a;
    wdata <= d;
    rd <= ~w;
    wr <= w;
    @(posedge clk);
    while (waitreq !== 1'b0) @(posedge clk);
    q = rdata;
    rd <= 1'b0;
    wr <= 1'b0;
    @(posedge clk);
  endtask

  function automatic logic [31:0] word(input int s, input logic [6:0] m, input logic [4:0] e);
    return {1'b0, m, 3'b0, e, 2'b0, want[s]};
  endfunction

  // Apply slot 1 inputs, check event, pendings, write-0 and write-1
  task automatic step(input slot_regs_pkg::slot_in_t nv, input logic [4:0] e);
    logic i;
    logic s;
    want[0] = nv;
    repeat (4) @(posedge clk);
    i = |(e & ~mask[4:0]);
    s = (e[4] & ~mask[6]) | (e[3] & ~mask[5]);
    bus(1'b0, 8'h24, '0);
    chk(q, word(0, mask, e));
    chk({30'b0, serr_p[0], irq_p[0]}, {30'b0, s, i});
    bus(1'b0, 8'h34, '0);
    chk(q, {20'h0, 3'b0, s, 7'h0, i});
    bus(1'b1, 8'h24, {1'b0, mask, 24'h0});
    bus(1'b0, 8'h24, '0);
    chk(q, word(0, mask, e));
    bus(1'b1, 8'h24, {1'b0, mask, 8'h1f, 16'h0});
    bus(1'b0, 8'h24, '0);
    chk(q, word(0, mask, 5'h0));
  endtask

  always @(posedge clk) begin
    cyc++;
    if (cyc == 5000) begin
      n_mismatch++;
      give_verdict();
    end
  end

  // ----------------------------------------------------------------
  // Main sequence
  // ----------------------------------------------------------------
  initial begin
    rst_b = 1'b0;
    rd = 1'b0;
    wr = 1'b0;
    addr = '0;
    wdata = '0;
    for (int s = 0; s < 4; s++) want[s] = {s[1:0], 2'b11, s[0], 3'b0, s[1:0], ~s[1:0], 2'b11};
    repeat (12) @(posedge clk);
    rst_b <= 1'b1;
    @(posedge clk);
    for (int s = 0; s < 4; s++) begin
      bus(1'b0, 8'h24 + 8'(4 * s), '0);
      chk(q, word(s, 7'h7f, 5'h0));
    end
    bus(1'b0, 8'h38, '0);
    chk(q, 32'h0);
    for (int k = 0; k < 3; k++) begin
      mask = pats[k];
      bus(1'b1, 8'h24, {1'b0, mask, 24'h0});
      bus(1'b0, 8'h24, '0);
      chk(q, word(0, mask, 5'h0));
    end
    v = want[0];
    v.slot_state = 2'b10;
    step(v, 5'h00);
    v.power_fault_latch = 1'b1;
    step(v, 5'h10);
    v.power_fault_latch = 1'b0;
    step(v, 5'h00);
    v.slot_state = 2'b01;
    step(v, 5'h00);
    v.power_fault_latch = 1'b1;
    step(v, 5'h02);
    v.retention_latch_open = 1'b1;
    step(v, 5'h08);
    v.retention_latch_open = 1'b0;
    step(v, 5'h08);
    v.attention_button_level = 1'b1;
    step(v, 5'h04);
    v.attention_button_level = 1'b0;
    step(v, 5'h00);
    v.card_presence_code = 2'b10;
    step(v, 5'h01);
    mask = 7'h7f;
    bus(1'b1, 8'h24, {1'b0, mask, 24'h0});
    v.retention_latch_open = 1'b1;
    step(v, 5'h08);
    mask = 7'h1f;
    bus(1'b1, 8'h24, {1'b0, mask, 24'h0});
    v.retention_latch_open = 1'b0;
    step(v, 5'h08);
    give_verdict();
  end
endmodule
